// ==== logic/eir_ext_irq.sv ====
`timescale 1ns/10ps

// Operation
// - two independent external inputs, each with own polarity and mode
// - polarity bit 0 means active low, 1 means active high
// - mode bit 1 selects edge detection, 0 selects level detection
// - a 3-bit field picks port 0 pin 0 through 7 per input
// - pin monitoring ignores crossbar routing and never disturbs the pin
// - pending flags sit in timer control bit 1 and bit 3
// - edge mode: active edge sets flag, vectoring to handler clears it
// - level mode: flag reads 1 while input active, 0 while inactive
// - level request still active after handler ends raises another request
module eir_ext_irq
  import eir_pkg::*;
(
  input  wire logic                  i_core_clk,
  input  wire logic                  i_rst_n,
  input  wire logic [EIR_PORT_W-1:0] i_port0_pins,
  input  wire logic [7:0]            i_sfr_addr,
  input  wire logic                  i_sfr_wr,
  input  wire logic [7:0]            i_sfr_wdata,
  input  wire logic [EIR_CHAN_N-1:0] i_irq_vector_ack,
  output logic      [7:0]            o_sfr_rdata,
  output logic      [EIR_CHAN_N-1:0] o_irq_pending
);

  // ---------------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------------
  logic [EIR_PORT_W-1:0] pin_meta_q;
  logic [EIR_PORT_W-1:0] pin_sync_q;
  logic [7:0]            cfg_q;
  logic [EIR_CHAN_N-1:0] edge_mode_q;
  logic                  cfg_wr;
  logic                  tctl_wr;
  eir_chan_cfg_t         chan_cfg [EIR_CHAN_N];
  logic [EIR_CHAN_N-1:0] sw_pend;
  logic [7:0]            rdata_d;

  // ---------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------
  // all eight pins are synchronised before the select mux, so changing
  // the select never routes a raw pin into the flag logic; the pins are
  // only read here, so a crossbar peripheral keeps the pin untouched
  genvar gi;
  generate
    for (gi = 0; gi < EIR_PORT_W; gi++) begin : g_sync
      always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
          pin_meta_q[gi] <= 1'b0;
          pin_sync_q[gi] <= 1'b0;
        end else begin
          pin_meta_q[gi] <= i_port0_pins[gi];
          pin_sync_q[gi] <= pin_meta_q[gi];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------------
  // address decode for the two registers this block answers to
  always_comb begin
    cfg_wr  = 1'b0;
    tctl_wr = 1'b0;
    if (i_sfr_wr && (i_sfr_addr == EIR_CFG_ADDR)) begin
      cfg_wr = 1'b1;
    end else if (i_sfr_wr && (i_sfr_addr == EIR_TCTL_ADDR)) begin
      tctl_wr = 1'b1;
    end
  end

  // pin configuration register: polarity and pin select per input
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      cfg_q <= EIR_CFG_RESET;
    end else if (cfg_wr) begin
      cfg_q <= i_sfr_wdata;
    end
  end

  // edge/level mode bits held in the timer control register
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      edge_mode_q <= {EIR_TCTL_RESET[EIR_TCTL_B_EDGE],
                      EIR_TCTL_RESET[EIR_TCTL_A_EDGE]};
    end else if (tctl_wr) begin
      edge_mode_q <= {i_sfr_wdata[EIR_TCTL_B_EDGE],
                      i_sfr_wdata[EIR_TCTL_A_EDGE]};
    end
  end

  // software-written pending values, used in edge mode only
  assign sw_pend = {i_sfr_wdata[EIR_TCTL_B_PEND],
                    i_sfr_wdata[EIR_TCTL_A_PEND]};

  // ---------------------------------------------------------------------
  // per-input setup
  // ---------------------------------------------------------------------
  assign chan_cfg[0] = '{
    polarity:   cfg_q[EIR_CFG_A_POL],
    pin_select: cfg_q[EIR_CFG_A_SEL_LSB +: EIR_SEL_W],
    edge_mode:  edge_mode_q[0]
  };
  assign chan_cfg[1] = '{
    polarity:   cfg_q[EIR_CFG_B_POL],
    pin_select: cfg_q[EIR_CFG_B_SEL_LSB +: EIR_SEL_W],
    edge_mode:  edge_mode_q[1]
  };

  // ---------------------------------------------------------------------
  // detectors
  // ---------------------------------------------------------------------
  // each input has its own detector and flag; both share the synchronised pins and the write strobe
  generate
    for (gi = 0; gi < EIR_CHAN_N; gi++) begin : g_chan
      eir_irq_detect u_detect (
        .i_core_clk   (i_core_clk),
        .i_rst_n      (i_rst_n),
        .i_cfg        (chan_cfg[gi]),
        .i_pins_sync  (pin_sync_q),
        .i_vector_ack (i_irq_vector_ack[gi]),
        .i_sw_wr      (tctl_wr),
        .i_sw_pend    (sw_pend[gi]),
        .o_pending    (o_irq_pending[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------------
  // the timer control view carries only this block's four bits; the
  // timer bits live elsewhere and read as zero here
  always_comb begin
    rdata_d = 8'h00;
    if (i_sfr_addr == EIR_CFG_ADDR) begin
      rdata_d = cfg_q;
    end else if (i_sfr_addr == EIR_TCTL_ADDR) begin
      rdata_d[EIR_TCTL_A_EDGE] = edge_mode_q[0];
      rdata_d[EIR_TCTL_A_PEND] = o_irq_pending[0];
      rdata_d[EIR_TCTL_B_EDGE] = edge_mode_q[1];
      rdata_d[EIR_TCTL_B_PEND] = o_irq_pending[1];
    end
  end

  // registered so the output comes straight from a flip-flop; costs one
  // cycle of read latency
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_sfr_rdata <= 8'h00;
    end else begin
      o_sfr_rdata <= rdata_d;
    end
  end

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  cfg_write_a : assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (i_sfr_wr && i_sfr_addr == EIR_CFG_ADDR)
      |=> (cfg_q == $past(i_sfr_wdata)))
    else $error("config write not stored");

  mode_write_a : assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (i_sfr_wr && i_sfr_addr == EIR_TCTL_ADDR)
      |=> (edge_mode_q[1] == $past(i_sfr_wdata[EIR_TCTL_B_EDGE]))
       && (edge_mode_q[0] == $past(i_sfr_wdata[EIR_TCTL_A_EDGE])))
    else $error("mode write not stored");

  pend_readback_a : assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (i_sfr_addr == EIR_TCTL_ADDR)
      |=> (o_sfr_rdata[EIR_TCTL_A_PEND] == $past(o_irq_pending[0]))
       && (o_sfr_rdata[EIR_TCTL_B_PEND] == $past(o_irq_pending[1])))
    else $error("pending flags not at bit 1 and bit 3");

  // only the four flag and mode bits answer in the timer control view;
  // every unmapped address reads as zero so stray reads stay harmless
  unmapped_zero_a : assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (i_sfr_addr != EIR_CFG_ADDR)
      |=> (o_sfr_rdata[7:4] == 4'h0)
       && ($past(i_sfr_addr) == EIR_TCTL_ADDR || o_sfr_rdata == 8'h00))
    else $error("unused read bits not zero");

  // the config register only moves on its own write strobe
  cfg_held_a : assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    !cfg_wr |=> $stable(cfg_q))
    else $error("config changed without a write");

  // both synchroniser stages must have left reset before the sample
  // can be held against the pin two edges back
  sync_two_stage_a : assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    ($past(i_rst_n) && $past(i_rst_n, 2))
      |-> (pin_sync_q == $past(i_port0_pins, 2)))
    else $error("pin sample not two cycles late");

  chan_isolated_a : assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (edge_mode_q[1] && i_irq_vector_ack[0] && !i_irq_vector_ack[1]
     && !tctl_wr && o_irq_pending[1]) |=> o_irq_pending[1])
    else $error("ack of one input touched the other");

  // three sampled cycles of an active-high pin 0 with a steady setup
  // must show as pending on the edge after them
  level_latency_a : assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (!edge_mode_q[0] && !cfg_wr && !tctl_wr
     && cfg_q[EIR_CFG_A_POL]
     && cfg_q[EIR_CFG_A_SEL_LSB +: EIR_SEL_W] == 3'h0
     && i_port0_pins[0]) [*3]
      |=> o_irq_pending[0])
    else $error("active-high level missed after three cycles");

endmodule : eir_ext_irq

// ==== logic/eir_irq_detect.sv ====
`timescale 1ns/10ps
module eir_irq_detect
  import eir_pkg::*;
(
  input  wire logic                  i_core_clk,
  input  wire logic                  i_rst_n,
  input  wire eir_chan_cfg_t         i_cfg,
  input  wire logic [EIR_PORT_W-1:0] i_pins_sync,
  input  wire logic                  i_vector_ack,
  input  wire logic                  i_sw_wr,
  input  wire logic                  i_sw_pend,
  output logic                       o_pending
);

  // ---------------------------------------------------------------------
  // pin pick and polarity correction
  // ---------------------------------------------------------------------
  logic pin_sel;
  logic active;
  logic active_prev_q;
  logic edge_hit;

  assign pin_sel  = i_pins_sync[i_cfg.pin_select];
  assign active   = i_cfg.polarity ? pin_sel : ~pin_sel;
  assign edge_hit = active & ~active_prev_q;

  // previous sample; resets high so a pin already active at reset
  // does not look like a fresh edge
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      active_prev_q <= 1'b1;
    end else begin
      active_prev_q <= active;
    end
  end

  // pending flag: edge mode latches, level mode follows the pin
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_pending <= 1'b0;
    end else if (i_cfg.edge_mode) begin
      if (edge_hit) begin
        o_pending <= 1'b1;
      end else if (i_sw_wr) begin
        o_pending <= i_sw_pend;
      end else if (i_vector_ack) begin
        o_pending <= 1'b0;
      end
    end else begin
      o_pending <= active;
    end
  end

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  edge_sets_flag_a : assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (i_cfg.edge_mode && edge_hit) |=> o_pending)
    else $error("edge did not set pending");

  vector_clears_a : assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (i_cfg.edge_mode && i_vector_ack && !edge_hit && !i_sw_wr)
      |=> !o_pending)
    else $error("vector did not clear pending");

  no_edge_idle_a : assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (i_cfg.edge_mode && !edge_hit && !i_sw_wr && !o_pending)
      |=> !o_pending)
    else $error("edge flag set without an edge");

  level_follows_a : assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    !i_cfg.edge_mode |=> (o_pending == $past(active)))
    else $error("level flag does not follow input");

  level_rerequest_a : assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (!i_cfg.edge_mode && active && i_vector_ack) |=> o_pending)
    else $error("still-active level did not re-request");

  low_polarity_a : assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (!i_cfg.edge_mode && !i_cfg.polarity && !pin_sel) |=> o_pending)
    else $error("active-low level not seen");

endmodule : eir_irq_detect

// ==== logic/eir_pkg.sv ====
package eir_pkg;

  // ---------------------------------------------------------------------
  // register addresses and reset values
  // ---------------------------------------------------------------------
  localparam logic [7:0] EIR_CFG_ADDR   = 8'hE4;
  localparam logic [7:0] EIR_TCTL_ADDR  = 8'h88;
  localparam logic [7:0] EIR_CFG_RESET  = 8'h00;
  localparam logic [7:0] EIR_TCTL_RESET = 8'h00;

  // ---------------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------------
  localparam int EIR_PORT_W = 8;
  localparam int EIR_SEL_W  = 3;
  localparam int EIR_CHAN_N = 2;

  // ---------------------------------------------------------------------
  // field positions in the pin configuration register
  // ---------------------------------------------------------------------
  localparam int EIR_CFG_A_SEL_LSB = 0;
  localparam int EIR_CFG_A_POL     = 3;
  localparam int EIR_CFG_B_SEL_LSB = 4;
  localparam int EIR_CFG_B_POL     = 7;

  // ---------------------------------------------------------------------
  // field positions in the timer control register (our bits only)
  // ---------------------------------------------------------------------
  localparam int EIR_TCTL_A_EDGE = 0;
  localparam int EIR_TCTL_A_PEND = 1;
  localparam int EIR_TCTL_B_EDGE = 2;
  localparam int EIR_TCTL_B_PEND = 3;

  // per-input setup carried to the detector
  typedef struct packed {
    logic                 polarity;
    logic [EIR_SEL_W-1:0] pin_select;
    logic                 edge_mode;
  } eir_chan_cfg_t;

endpackage : eir_pkg

// ==== testbench/eir_irq_source.sv ====
`timescale 1ns/10ps
module eir_irq_source
  import eir_pkg::*;
(
  input  wire logic                  i_core_clk,
  output logic      [EIR_PORT_W-1:0] o_pins
);
  // ---------------------------------------------------------------------
  // external request lines on port 0
  // ---------------------------------------------------------------------
  // weak pull-ups hold every pin high until a source drives it
  initial begin
    o_pins = 8'hFF;
  end

  // park all lines at one level, changed just after an edge
  task automatic set_all(input logic lvl);
    @(posedge i_core_clk);
    o_pins <= {EIR_PORT_W{lvl}};
  endtask : set_all

  // a source raises its line and holds it, whatever the controller does,
  // until it is told to let go; withdrawal is the caller's decision
  task automatic set_pin(input logic [2:0] pin, input logic lvl);
    @(posedge i_core_clk);
    o_pins[pin] <= lvl;
  endtask : set_pin
endmodule : eir_irq_source

// ==== testbench/testbench.sv ====
`timescale 1ns/10ps
module testbench
  import eir_pkg::*;
;
  logic                  core_clk;
  logic                  rst_n;
  logic [EIR_PORT_W-1:0] pins;
  logic [7:0]            sfr_addr;
  logic                  sfr_wr;
  logic [7:0]            sfr_wdata;
  logic [EIR_CHAN_N-1:0] vec_ack;
  logic [7:0]            sfr_rdata;
  logic [EIR_CHAN_N-1:0] irq_pending;
  int                    err_total;
  int                    checked;

  eir_ext_irq eir_ext_irq_inst (
    .i_core_clk       (core_clk),
    .i_rst_n          (rst_n),
    .i_port0_pins     (pins),
    .i_sfr_addr       (sfr_addr),
    .i_sfr_wr         (sfr_wr),
    .i_sfr_wdata      (sfr_wdata),
    .i_irq_vector_ack (vec_ack),
    .o_sfr_rdata      (sfr_rdata),
    .o_irq_pending    (irq_pending)
  );

  eir_irq_source eir_irq_source_inst (
    .i_core_clk (core_clk),
    .o_pins     (pins)
  );

  // ---------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sfr_addr  <= a;
    sfr_wr    <= 1'b1;
    sfr_wdata <= d;
    @(posedge core_clk);
    sfr_wr    <= 1'b0;
  endtask : wr

  // read data is registered: valid one edge after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    sfr_addr <= a;
    @(posedge core_clk);
    #1;
    d = sfr_rdata;
  endtask : rd

  task automatic ack(input int ch);
    @(posedge core_clk);
    vec_ack[ch] <= 1'b1;
    @(posedge core_clk);
    vec_ack[ch] <= 1'b0;
    #1;
  endtask : ack

  // two sync flops plus the flag register: three edges, one spare
  task automatic settle;
    repeat (4) @(posedge core_clk);
    #1;
  endtask : settle

  function automatic logic [7:0] pend(input int ch);
    return {7'h00, irq_pending[ch]};
  endfunction : pend

  // ---------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------
  task automatic t_regs;
    logic [7:0] d;
    rd(EIR_CFG_ADDR, d);
    chk("cfg reset", d, 8'h00);
    rd(EIR_TCTL_ADDR, d);
    chk("ctl reset", d, 8'h00);
    chk("pend idle", {6'h00, irq_pending}, 8'h00);
    wr(EIR_CFG_ADDR, 8'h89);
    rd(EIR_CFG_ADDR, d);
    chk("cfg rw", d, 8'h89);
    wr(8'hE5, 8'h5A);
    rd(8'hE5, d);
    chk("unmapped", d, 8'h00);
    rd(EIR_CFG_ADDR, d);
    chk("cfg kept", d, 8'h89);
    // both inputs are active high on high pins, so both flags are up
    // when the mode flips to edge and they carry over
    wr(EIR_TCTL_ADDR, 8'hF5);
    rd(EIR_TCTL_ADDR, d);
    chk("ctl rw", d, 8'h0F);
    wr(EIR_TCTL_ADDR, 8'h00);
    $display("test regs done");
  endtask : t_regs

  // every polarity and every pin code in level mode
  task automatic t_level(input int ch);
    logic       p;
    logic [2:0] s;
    for (int k = 0; k < 16; k++) begin
      p = k[3];
      s = k[2:0];
      eir_irq_source_inst.set_all(~p);
      wr(EIR_CFG_ADDR, ch ? {p, s, p, ~s} : {p, ~s, p, s});
      settle();
      chk("level off", pend(ch), 8'h00);
      eir_irq_source_inst.set_pin(s, p);
      settle();
      chk("level on", pend(ch), 8'h01);
    end
    $display("test level done");
  endtask : t_level

  task automatic t_edge(input int ch, input logic p, input logic [2:0] s);
    logic [7:0] d;
    logic [7:0] eb;
    eb = ch ? 8'h04 : 8'h01;
    eir_irq_source_inst.set_all(~p);
    wr(EIR_CFG_ADDR, ch ? {p, s, p, ~s} : {p, ~s, p, s});
    wr(EIR_TCTL_ADDR, eb);
    settle();
    chk("edge idle", pend(ch), 8'h00);
    eir_irq_source_inst.set_pin(s, p);
    settle();
    chk("edge set", pend(ch), 8'h01);
    rd(EIR_TCTL_ADDR, d);
    chk("ctl pend", d, eb | (eb << 1));
    eir_irq_source_inst.set_pin(s, ~p);
    settle();
    chk("edge held", pend(ch), 8'h01);
    ack(1 - ch);
    chk("other ack", pend(ch), 8'h01);
    ack(ch);
    chk("edge clear", pend(ch), 8'h00);
    wr(EIR_TCTL_ADDR, eb | (eb << 1));
    #1;
    chk("sw set", pend(ch), 8'h01);
    wr(EIR_TCTL_ADDR, 8'h00);
    $display("test edge done");
  endtask : t_edge

  // level request still up after the handler: the flag must stay up
  task automatic t_level_ack;
    eir_irq_source_inst.set_all(1'b0);
    wr(EIR_CFG_ADDR, 8'hE9);
    eir_irq_source_inst.set_pin(3'd6, 1'b1);
    settle();
    chk("lvl up", pend(1), 8'h01);
    ack(1);
    chk("lvl after ack", pend(1), 8'h01);
    eir_irq_source_inst.set_pin(3'd6, 1'b0);
    settle();
    chk("lvl gone", pend(1), 8'h00);
    wr(EIR_TCTL_ADDR, 8'h08);
    @(posedge core_clk);
    #1;
    chk("lvl no sw set", pend(1), 8'h00);
    $display("test level ack done");
  endtask : t_level_ack

  // ---------------------------------------------------------------------
  // run control
  // ---------------------------------------------------------------------
  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize

  // the whole run is under 2000 cycles; this span is ample
  initial begin
    #200us;
    err_total++;
    summarize();
  end

  initial begin
    rst_n     = 1'b0;
    sfr_addr  = 8'h00;
    sfr_wr    = 1'b0;
    sfr_wdata = 8'h00;
    vec_ack   = 2'b00;
    err_total = 0;
    checked   = 0;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    t_regs();
    t_level(0);
    t_level(1);
    t_edge(0, 1'b1, 3'd2);
    t_edge(1, 1'b0, 3'd5);
    t_level_ack();
    summarize();
  end
endmodule : testbench
